// >>> rtl/range_pkg.sv
package range_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CLEAR  = 8'h08;

    // range code bounds and reset value
    localparam logic [3:0] RANGE_MIN   = 4'h2;
    localparam logic [3:0] RANGE_MAX   = 4'he;
    localparam logic [3:0] RANGE_RESET = 4'h2;
    localparam int         NUM_RANGES  = 13;

    // loop filter thresholds in external mode (range below -> code)
    localparam logic [3:0] LF_EDGE1 = 4'h6;
    localparam logic [3:0] LF_EDGE2 = 4'ha;
    localparam logic [3:0] LF_EDGE3 = 4'hd;

    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int DIR_SETUP_NS  = 10;
    localparam int LOCK_DELAY_NS = 90;
    localparam int LOCKOUT_US    = 80;
    localparam int DIR_SETUP_CYC = (DIR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOCK_DELAY_CYC = (LOCK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOCKOUT_CYC   = (LOCKOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 10;

    // control register layout
    typedef struct packed {
        logic       cal_half_octave_value; // bit 8
        logic       cal_override_sel;      // bit 7
        logic       host_loop_filter_bit1; // bit 6
        logic       host_loop_filter_bit0; // bit 5
        logic       ext_mode;              // bit 4
        logic [3:0] range_value;           // bits 3:0
    } ctrl_t;
    localparam int CTRL_W = 9;

    // status register layout
    typedef struct packed {
        logic [1:0] loop_filter;       // bits 9:8
        logic       lockout;           // bit 7
        logic       half_octave_bit;   // bit 6
        logic       out_of_range_flag; // bit 5
        logic       unlock_flag;       // bit 4
        logic [3:0] range_code;        // bits 3:0
    } status_t;

    localparam int CLEAR_BIT = 0;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SETUP,
        ST_HOLD,
        ST_LOCKOUT
    } step_state_t;
endpackage : range_pkg

// >>> rtl/octave_range_select.sv
// The implementer's own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ns
// Operation
// - thirteen octave ranges held in up/down counter
// - external mode judges tuning voltage low/high
// - too-low indication steps range down one
// - active-low too-high steps range up one
// - direction settles before the counting edge
// - lockout 80us after each range step
// - lockout starts from step delayed 90ns
// - filter bits from range, or host bits
// - either phase indication sets unlock flag
// - no step outside range codes 2..14
// - step needed at endpoint sets out-of-range
// - flags latched until host clear pulse
// - half-octave bit is inverted mid comparator
// - calibration select overrides half-octave bit
module octave_range_select
    import range_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    input  wire logic        TOO_LOW,
    input  wire logic        TOO_HIGH_N,
    input  wire logic        MID_CMP,
    input  wire logic        PHASE_RISING,
    input  wire logic        PHASE_FALLING_N,
    output logic      [3:0]  RANGE,
    output logic             STEP_UP,
    output logic             STEP_CLK,
    output logic      [1:0]  LOOP_FILTER,
    output logic             HALF_OCTAVE,
    output logic             UNLOCK,
    output logic             OUT_OF_RANGE
);
    import range_pkg::*;

    localparam int NSYNC = 5;
    // reset to the idle pin levels, else a false too-high or phase event follows reset
    localparam logic [NSYNC-1:0] SYNC_IDLE = 5'h12;

    function automatic logic [1:0] filter_of(input logic [3:0] r);
        if (r < LF_EDGE1)
            filter_of = 2'h0;
        else if (r < LF_EDGE2)
            filter_of = 2'h1;
        else if (r < LF_EDGE3)
            filter_of = 2'h2;
        else
            filter_of = 2'h3;
    endfunction : filter_of

    // two-flop synchronisers; only stage 2 is looked at
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;
    logic [NSYNC-1:0] raw_in;
    assign raw_in = {PHASE_FALLING_N, PHASE_RISING, MID_CMP, TOO_HIGH_N, TOO_LOW};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++)
        begin : g_sync
            always_ff @(posedge CLK or posedge SYS_RST)
            begin
                if (SYS_RST)
                begin
                    sync1[gi] <= SYNC_IDLE[gi];
                    sync2[gi] <= SYNC_IDLE[gi];
                end
                else
                begin
                    sync1[gi] <= raw_in[gi];
                    sync2[gi] <= sync1[gi];
                end
            end
        end
    endgenerate

    logic want_down;
    logic want_up;
    logic mid_s;
    logic phase_bad;
    assign want_down = sync2[0];
    assign want_up   = ~sync2[1];
    assign mid_s     = sync2[2];
    assign phase_bad = sync2[3] | ~sync2[4];

    // bus slave
    ctrl_t       ctrl;
    ctrl_t       next_ctrl;
    logic        ack;
    logic        next_ack;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic        wr_ctrl;
    logic        flag_clear_n;
    status_t     stat;
    logic        bus_req;

    assign bus_req = WB_CYC_I & WB_STB_I & ~ack;

    always_comb
    begin
        next_ctrl = ctrl;
        next_ack = bus_req;
        next_rdata = 32'h0000_0000;
        wr_ctrl = 1'b0;
        flag_clear_n = 1'b1;
        if (bus_req && WB_WE_I)
        begin
            case (WB_ADR_I)
                ADDR_CTRL:
                begin
                    // cal bits arrive in the same write as range and filter bits
                    if (WB_SEL_I[0])
                        next_ctrl[7:0] = WB_DAT_I[7:0];
                    if (WB_SEL_I[1])
                        next_ctrl[8] = WB_DAT_I[8];
                    wr_ctrl = WB_SEL_I[0];
                end
                ADDR_CLEAR:
                    flag_clear_n = ~(WB_SEL_I[0] & WB_DAT_I[CLEAR_BIT]);
                default:
                    next_ctrl = ctrl;
            endcase
        end
        else if (bus_req)
        begin
            case (WB_ADR_I)
                ADDR_CTRL:   next_rdata = {{(32-CTRL_W){1'b0}}, ctrl};
                ADDR_STATUS: next_rdata = {22'h0, stat};
                default:     next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            ctrl  <= '0;
            ack   <= 1'b0;
            rdata <= 32'h0000_0000;
        end
        else
        begin
            ctrl  <= next_ctrl;
            ack   <= next_ack;
            rdata <= next_rdata;
        end
    end

    assign WB_ACK_O = ack;
    assign WB_DAT_O = rdata;

    // range stepping
    step_state_t      state;
    step_state_t      next_state;
    logic [3:0]       range_code;
    logic [3:0]       next_range;
    logic             dir_up;
    logic             next_dir_up;
    logic             step_clk;
    logic             next_step_clk;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic             oor_hit;
    logic             at_end;

    always_comb
    begin
        next_state = state;
        next_range = range_code;
        next_dir_up = dir_up;
        next_step_clk = 1'b0;
        next_cnt = cnt;
        oor_hit = 1'b0;
        at_end = (want_up && range_code >= RANGE_MAX) || (want_down && range_code <= RANGE_MIN);
        if (!ctrl.ext_mode)
        begin
            // internal mode: host owns the counter, no hardware stepping
            next_state = ST_IDLE;
            if (wr_ctrl)
                next_range = next_ctrl.range_value;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    if (want_up ^ want_down)
                    begin
                        if (at_end)
                            oor_hit = 1'b1;
                        else
                        begin
                            next_dir_up = want_up;
                            next_cnt = CNT_W'(DIR_SETUP_CYC);
                            next_state = ST_SETUP;
                        end
                    end
                    else if (want_up && want_down)
                        oor_hit = 1'b0;
                end
                ST_SETUP:
                begin
                    if (cnt > CNT_W'(1))
                        next_cnt = cnt - CNT_W'(1);
                    else
                    begin
                        // count edge after direction has settled
                        next_step_clk = 1'b1;
                        if (dir_up && range_code < RANGE_MAX)
                            next_range = range_code + 4'h1;
                        else if (!dir_up && range_code > RANGE_MIN)
                            next_range = range_code - 4'h1;
                        next_cnt = CNT_W'(LOCK_DELAY_CYC);
                        next_state = ST_HOLD;
                    end
                end
                ST_HOLD:
                begin
                    // step pulse stays whole until the delayed trigger
                    if (cnt > CNT_W'(1))
                    begin
                        next_step_clk = 1'b1;
                        next_cnt = cnt - CNT_W'(1);
                    end
                    else
                    begin
                        next_cnt = CNT_W'(LOCKOUT_CYC);
                        next_state = ST_LOCKOUT;
                    end
                end
                ST_LOCKOUT:
                begin
                    if (cnt > CNT_W'(1))
                        next_cnt = cnt - CNT_W'(1);
                    else
                    begin
                        next_cnt = '0;
                        next_state = ST_IDLE;
                    end
                end
                default:
                    next_state = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            state      <= ST_IDLE;
            range_code <= RANGE_RESET;
            dir_up     <= 1'b0;
            step_clk   <= 1'b0;
            cnt        <= '0;
        end
        else
        begin
            state      <= next_state;
            range_code <= next_range;
            dir_up     <= next_dir_up;
            step_clk   <= next_step_clk;
            cnt        <= next_cnt;
        end
    end

    // flags, filter and half-octave outputs
    logic       unlock_flag;
    logic       next_unlock;
    logic       out_of_range_flag;
    logic       next_oor;
    logic [1:0] loop_filter;
    logic [1:0] next_lf;
    logic       half_octave_bit;
    logic       next_half;

    always_comb
    begin
        // a set in the same cycle as the clear wins
        next_unlock = (unlock_flag & flag_clear_n) | phase_bad;
        next_oor = (out_of_range_flag & flag_clear_n) | oor_hit;
        if (ctrl.ext_mode)
            next_lf = filter_of(next_range);
        else
            next_lf = {ctrl.host_loop_filter_bit1, ctrl.host_loop_filter_bit0};
        if (ctrl.cal_override_sel)
            next_half = ctrl.cal_half_octave_value;
        else
            next_half = ~mid_s;
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            unlock_flag       <= 1'b0;
            out_of_range_flag <= 1'b0;
            loop_filter       <= 2'h0;
            half_octave_bit   <= 1'b0;
        end
        else
        begin
            unlock_flag       <= next_unlock;
            out_of_range_flag <= next_oor;
            loop_filter       <= next_lf;
            half_octave_bit   <= next_half;
        end
    end

    assign stat.loop_filter       = loop_filter;
    assign stat.lockout           = (state != ST_IDLE);
    assign stat.half_octave_bit   = half_octave_bit;
    assign stat.out_of_range_flag = out_of_range_flag;
    assign stat.unlock_flag       = unlock_flag;
    assign stat.range_code        = range_code;

    assign RANGE        = range_code;
    assign STEP_UP      = dir_up;
    assign STEP_CLK     = step_clk;
    assign LOOP_FILTER  = loop_filter;
    assign HALF_OCTAVE  = half_octave_bit;
    assign UNLOCK       = unlock_flag;
    assign OUT_OF_RANGE = out_of_range_flag;
endmodule : octave_range_select

// >>> bench/range_checker_sva.sv
`timescale 1ns/1ns
module range_checker
    import range_pkg::*;
(
    input wire logic       CLK,
    input wire logic       SYS_RST,
    input wire logic       WB_STB_I,
    input wire logic       WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic       WB_ACK_O,
    input wire logic       PHASE_RISING,
    input wire logic       PHASE_FALLING_N,
    input wire logic [3:0] RANGE,
    input wire logic       STEP_UP,
    input wire logic       STEP_CLK,
    input wire logic       UNLOCK,
    input wire logic       OUT_OF_RANGE
);
    logic       clr;
    logic [9:0] gap;
    logic [9:0] next_gap;
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    // sel and data are not decoded, so a clear request only excuses the flags
    assign clr = WB_STB_I && WB_WE_I && WB_ADR_I == ADDR_CLEAR && !WB_ACK_O;
    always_comb next_gap = STEP_CLK ? 10'h0 : (&gap ? gap : gap + 10'h1);
    always_ff @(posedge CLK or posedge SYS_RST)
        if (SYS_RST) gap <= '1;
        else gap <= next_gap;
    chk_step_up_one: assert property ($rose(STEP_CLK) && STEP_UP |-> RANGE == $past(RANGE) + 4'h1)
        else $error("up step did not add one");
    chk_step_down_one: assert property ($rose(STEP_CLK) && !STEP_UP |-> RANGE == $past(RANGE) - 4'h1)
        else $error("down step did not take one");
    chk_step_in_bounds: assert property ($rose(STEP_CLK) |-> RANGE >= RANGE_MIN && RANGE <= RANGE_MAX)
        else $error("step left the range bounds");
    chk_direction_first: assert property ($rose(STEP_CLK) |-> STEP_UP == $past(STEP_UP))
        else $error("direction changed with the step");
    chk_step_single_cycle: assert property ($rose(STEP_CLK) |=> !STEP_CLK)
        else $error("step pulse too long");
    chk_lockout_gap: assert property ($rose(STEP_CLK) |-> gap >= 10'(LOCKOUT_CYC))
        else $error("step inside lockout");
    chk_unlock_sets: assert property ((PHASE_RISING || !PHASE_FALLING_N) [*3] |=> UNLOCK)
        else $error("unlock flag not set");
    chk_unlock_holds: assert property (UNLOCK && !clr |=> UNLOCK)
        else $error("unlock flag dropped");
    chk_range_flag_holds: assert property (OUT_OF_RANGE && !clr |=> OUT_OF_RANGE)
        else $error("out of range flag dropped");
    cover property ($rose(STEP_CLK) && STEP_UP);
    cover property ($rose(STEP_CLK) && !STEP_UP);
    cover property ($rose(OUT_OF_RANGE));
endmodule : range_checker

bind octave_range_select range_checker chk (.CLK(CLK), .SYS_RST(SYS_RST), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_ACK_O(WB_ACK_O), .PHASE_RISING(PHASE_RISING),
    .PHASE_FALLING_N(PHASE_FALLING_N), .RANGE(RANGE), .STEP_UP(STEP_UP), .STEP_CLK(STEP_CLK),
    .UNLOCK(UNLOCK), .OUT_OF_RANGE(OUT_OF_RANGE));

// >>> bench/tuning_comparators.sv
`timescale 1ns/1ns
module tuning_comparators
#(
    parameter logic [7:0] LOW_SET  = 8'h14,
    parameter logic [7:0] HIGH_SET = 8'h50,
    parameter logic [7:0] MID_SET  = 8'h32
)
(
    input wire logic [7:0] half_tuning_voltage,
    input wire logic       locked,
    input wire logic       slip_up,
    output logic           too_low,
    output logic           too_high_n,
    output logic           mid_cmp,
    output logic           phase_rising,
    output logic           phase_falling_n
);
    assign too_low = half_tuning_voltage < LOW_SET;
    assign too_high_n = !(half_tuning_voltage > HIGH_SET);
    // low in the upper half of the octave
    assign mid_cmp = half_tuning_voltage <= MID_SET;
    // an unlocked loop slips one way at a time
    assign phase_rising = !locked && slip_up;
    assign phase_falling_n = locked || slip_up;
endmodule : tuning_comparators

// >>> bench/octave_range_select_logic_test.sv
`timescale 1ns/1ns
module octave_range_select_logic_test;
    import range_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [7:0]  vtun = 8'h3c;
    logic        locked = 1'b1;
    logic        slip = 1'b0;
    logic [31:0] rdat;
    logic [3:0]  rng;
    logic [1:0]  lf;
    logic        ack, lo, hi_n, mid, ph_r, ph_f_n, up, stp, half, unl, oor;
    logic [8:0]  exp_q[$];
    logic [31:0] rd_q[$];
    int          miscompares = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    event        look;

    always #50 clk = ~clk;

    octave_range_select DUT (.CLK(clk), .SYS_RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .TOO_LOW(lo),
        .TOO_HIGH_N(hi_n), .MID_CMP(mid), .PHASE_RISING(ph_r), .PHASE_FALLING_N(ph_f_n), .RANGE(rng),
        .STEP_UP(up), .STEP_CLK(stp), .LOOP_FILTER(lf), .HALF_OCTAVE(half), .UNLOCK(unl), .OUT_OF_RANGE(oor));
    tuning_comparators far_end (.half_tuning_voltage(vtun), .locked(locked), .slip_up(slip), .too_low(lo),
        .too_high_n(hi_n), .mid_cmp(mid), .phase_rising(ph_r), .phase_falling_n(ph_f_n));

    task automatic bad(input string m);
        miscompares++;
        $display("mismatch at %0t: %s", $time, m);
    endtask : bad
    task automatic cmp_out(input logic [8:0] e);
        samples_checked++;
        if ({rng, lf, half, unl, oor} !== e)
            bad($sformatf("outputs %h expected %h", {rng, lf, half, unl, oor}, e));
    endtask : cmp_out
    task automatic cmp_rd(input logic [31:0] e);
        samples_checked++;
        if (rdat !== e)
            bad($sformatf("read %h expected %h", rdat, e));
    endtask : cmp_rd
    task automatic complete_run();
        $display("compared %0d, mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run
    // the request stays put until ack is seen, then falls for a cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic ctrl(input logic x, input logic s, input logic c, input logic [1:0] f, input logic [3:0] r);
        wb(1'b1, ADDR_CTRL, {23'h0, c, s, f, x, r});
    endtask : ctrl
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask : rd
    task automatic want(input logic [8:0] e);
        @(negedge clk);
        exp_q.push_back(e);
        -> look;
        @(posedge clk);
    endtask : want

    always @(look) cmp_out(exp_q.pop_front());
    always @(posedge clk)
        if (ack === 1'b1 && we === 1'b0) cmp_rd(rd_q.pop_front());
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad("timeout");
            complete_run();
        end
    end

    initial
    begin
        logic [3:0] r;
        logic [1:0] f;
        logic       c;
        void'($urandom(32'h6882b852));
        repeat (3) @(posedge clk);
        want({RANGE_RESET, 5'h00});
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 4; i++)
        begin
            r = 4'($urandom_range(14, 2));
            f = 2'($urandom);
            c = 1'($urandom);
            ctrl(1'b0, 1'b1, c, f, r);
            want({r, f, c, 2'b00});
            rd(ADDR_STATUS, {22'h0, f, 1'b0, c, 2'b00, r});
        end
        rd(8'h0c, 32'h0);
        ctrl(1'b0, 1'b0, 1'b0, 2'h0, 4'h7);
        vtun <= 8'h28;
        repeat (4) @(posedge clk);
        want({4'h7, 5'h00});
        vtun <= 8'h3c;
        repeat (4) @(posedge clk);
        want({4'h7, 5'h04});
        $display("internal mode test done");
        for (int s = 0; s < 2; s++)
        begin
            slip <= 1'(s);
            locked <= 1'b0;
            repeat (4) @(posedge clk);
            locked <= 1'b1;
            repeat (4) @(posedge clk);
            want({4'h7, 5'h06});
            wb(1'b1, ADDR_CLEAR, 32'h1);
            want({4'h7, 5'h04});
        end
        $display("unlock test done");
        ctrl(1'b0, 1'b0, 1'b0, 2'h0, 4'hd);
        ctrl(1'b1, 1'b0, 1'b0, 2'h0, 4'hd);
        vtun <= 8'h5a;
        repeat (10) @(posedge clk);
        want({4'he, 2'h3, 3'b100});
        repeat (LOCKOUT_CYC + 20) @(posedge clk);
        want({4'he, 2'h3, 3'b101});
        vtun <= 8'h3c;
        // let the endpoint condition leave the synchroniser, or the set beats the clear
        repeat (4) @(posedge clk);
        wb(1'b1, ADDR_CLEAR, 32'h1);
        want({4'he, 2'h3, 3'b100});
        $display("step up test done");
        ctrl(1'b0, 1'b0, 1'b0, 2'h0, 4'h4);
        ctrl(1'b1, 1'b0, 1'b0, 2'h0, 4'h4);
        vtun <= 8'h0a;
        repeat (10) @(posedge clk);
        want({4'h3, 5'h00});
        repeat (400) @(posedge clk);
        want({4'h3, 5'h00});
        repeat (420) @(posedge clk);
        want({4'h2, 5'h00});
        repeat (LOCKOUT_CYC + 20) @(posedge clk);
        want({4'h2, 5'h01});
        ctrl(1'b0, 1'b0, 1'b0, 2'h0, 4'h2);
        $display("step down test done");
        complete_run();
    end
endmodule : octave_range_select_logic_test
